// File: src/rps_buffer.sv
// 256-byte packet buffer, one write port and two read ports
`timescale 1ns/10ps
module rps_buffer import rps_pkg::*; (
  input  wire logic              i_clock,
  input  wire logic              i_we,
  input  wire logic [RPS_AW-1:0] i_waddr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic [RPS_AW-1:0] i_raddr_a,
  output logic      [7:0]        o_rdata_a,
  input  wire logic [RPS_AW-1:0] i_raddr_b,
  output logic      [7:0]        o_rdata_b
);
  logic [7:0] mem [RPS_BUF_DEPTH];

  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata_a = mem[i_raddr_a];
  assign o_rdata_b = mem[i_raddr_b];
endmodule

// File: src/rps_pkg.sv
// Shared constants and types of the radio packet sequencer
package rps_pkg;
  localparam int          RPS_BUF_DEPTH  = 256;
  localparam int          RPS_AW         = 8;
  localparam logic [8:0]  RPS_CLR_LAST   = 9'h0FF;
  // Register byte offsets
  localparam logic [7:0]  OFF_MODE       = 8'h00;
  localparam logic [7:0]  OFF_FLAGS      = 8'h04;
  localparam logic [7:0]  OFF_ACC_PTR    = 8'h08;
  localparam logic [7:0]  OFF_DATA       = 8'h0C;
  localparam logic [7:0]  OFF_TX_START   = 8'h10;
  localparam logic [7:0]  OFF_RX_START   = 8'h14;
  localparam logic [7:0]  OFF_LAST_START = 8'h18;
  localparam logic [7:0]  OFF_RX_COUNT   = 8'h1C;
  localparam logic [7:0]  OFF_RX_WPOS    = 8'h20;
  localparam logic [7:0]  OFF_TX_SIZE    = 8'h24;
  localparam logic [7:0]  OFF_WIN_LEN    = 8'h28;
  localparam logic [7:0]  OFF_PRE_LEN    = 8'h2C;
  // Mode codes
  localparam logic [2:0]  MODE_SLEEP     = 3'h0;
  localparam logic [2:0]  MODE_STANDBY   = 3'h1;
  localparam logic [2:0]  MODE_TX_SYNTH  = 3'h2;
  localparam logic [2:0]  MODE_TX        = 3'h3;
  localparam logic [2:0]  MODE_RX_SYNTH  = 3'h4;
  localparam logic [2:0]  MODE_RX_CONT   = 3'h5;
  localparam logic [2:0]  MODE_RX_SINGLE = 3'h6;
  // Event flag bit positions
  localparam int          FLG_TX_DONE    = 0;
  localparam int          FLG_RX_DONE    = 1;
  localparam int          FLG_EXPIRED    = 2;
  localparam int          FLG_CHK_FAIL   = 3;
  localparam int          FLG_HDR_OK     = 4;
  // Reset values
  localparam logic [7:0]  RST_TX_START   = 8'h80;
  localparam logic [7:0]  RST_RX_START   = 8'h00;
  localparam logic [7:0]  RST_TX_SIZE    = 8'h01;
  localparam logic [9:0]  RST_WIN_LEN    = 10'h005;
  localparam logic [15:0] RST_PRE_LEN    = 16'h0008;
  localparam int          RPS_LINK_W     = 16;

  typedef enum logic [1:0] {RX_IDLE, RX_SEARCH, RX_PREAMBLE, RX_PAYLOAD} rps_rx_state_t;

  // Modem-side signals, sampled at each rising edge of the link clock
  typedef struct packed {
    logic       lclk;
    logic       pre_det;
    logic       hdr_ok;
    logic       byte_valid;
    logic [7:0] rx_byte;
    logic       rx_end;
    logic       crc_bad;
    logic       tx_take;
    logic       tx_end;
  } rps_link_t;
endpackage

// File: src/rps_sequencer.sv
// Packet sequencer: modes, event flags, packet buffer pointers, APB registers
`timescale 1ns/10ps
// Function
// (RULE_01) Host changes configuration only in idle modes
// (RULE_02) Host loads transmit bytes only in standby
// (RULE_03) Transmit sends packet, flags, returns standby
// (RULE_04) Host sets pointer, writes payload size bytes
// (RULE_05) Single receive window expiry flags, goes standby
// (RULE_06) Receive end flags, check fail, bytes kept
// (RULE_07) Single receive ends: RF off, standby
// (RULE_08) Preamble fixes gain; header flag raised
// (RULE_09) Host resets pointer and reselects single receive
// (RULE_10) Continuous receive searches again after packet
// (RULE_11) Overlong preamble dropped silently, search restarts
// (RULE_12) Continuous timeout flags but keeps mode
// (RULE_13) Continuous packets stored back to back
// (RULE_14) Continuous receive flags and stays after packet
// (RULE_15) Status kept only for latest packet
// (RULE_16) Host discards packets showing error flags
// (RULE_17) Received byte count tracks current packet
// (RULE_18) Host reads from last packet start
// (RULE_19) Host may read from write position minus count
// (RULE_20) Write position shows next receive address
// (RULE_21) Host filters address after four bytes
// (RULE_22) 256-byte buffer, refused in sleep
// (RULE_23) Data port access advances pointer
// (RULE_24) Sleep entry clears buffer contents
// (RULE_25) Eight-bit pointers wrap to zero
module rps_sequencer import rps_pkg::*; (
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire rps_link_t   i_link,
  output logic             o_rf_en,
  output logic             o_pll_en,
  output logic             o_pa_en,
  output logic             o_gain_hold,
  output logic      [7:0]  o_tx_byte,
  output logic      [7:0]  o_tx_size
);
  rps_link_t     lk;
  rps_rx_state_t rx_state_reg;
  logic [2:0]  mode_reg, mode_prev_reg;
  logic [4:0]  flags_reg;
  logic [7:0]  acc_ptr_reg, tx_ptr_reg, tx_start_reg, rx_start_reg, tx_size_reg;
  logic [7:0]  wpos_reg, cur_start_reg, last_start_reg, rx_count_reg;
  logic [9:0]  win_len_reg, win_cnt_reg;
  logic [15:0] pre_len_reg, pre_cnt_reg;
  logic        lclk_prev_reg, enter_reg, fired_reg, clr_active_reg;
  logic [8:0]  clr_addr_reg;
  logic        pready_reg, pslverr_reg;
  logic [31:0] prdata_reg, rdata_mux;
  logic [7:0]  buf_rd, tx_rd, buf_wdata, buf_waddr;
  logic        tick, rx_on, single, cont, access, data_acc, stall, xfer, wr, mapped;
  logic        mode_wr, mode_legal, rx_byte_evt, rx_end_evt, hdr_evt, tx_end_evt;
  logic        expire_evt, buf_we;
  logic [4:0]  flag_set, flag_clr;

  rps_sync #(.W(RPS_LINK_W)) u_sync (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_async (i_link),
    .o_sync  (lk)
  );

  assign tick        = lk.lclk & ~lclk_prev_reg;
  assign single      = (mode_reg == MODE_RX_SINGLE);
  assign cont        = (mode_reg == MODE_RX_CONT);
  assign rx_on       = single | cont;
  assign access      = i_psel & i_penable & ~pready_reg;
  assign data_acc    = access & (i_paddr == OFF_DATA);
  assign rx_byte_evt = tick & lk.byte_valid & (rx_state_reg == RX_PAYLOAD);
  assign rx_end_evt  = tick & lk.rx_end & (rx_state_reg == RX_PAYLOAD);
  assign hdr_evt     = tick & lk.hdr_ok & (rx_state_reg == RX_PREAMBLE);
  assign tx_end_evt  = tick & lk.tx_end & (mode_reg == MODE_TX);
  // Buffer port yields to the modem and to the clearing sweep
  assign stall       = data_acc & (mode_reg != MODE_SLEEP) & (rx_byte_evt | clr_active_reg);
  assign xfer        = access & ~stall;
  assign wr          = xfer & i_pwrite;
  assign mode_legal  = (i_pwdata[2:0] <= MODE_RX_SINGLE);
  assign mode_wr     = wr & (i_paddr == OFF_MODE) & mode_legal;
  // (RULE_05) window expiry while searching
  assign expire_evt  = tick & rx_on & ~fired_reg & (rx_state_reg == RX_SEARCH)
                       & (win_cnt_reg >= win_len_reg);

  // Buffer write port: clear sweep, then modem, then host
  always_comb begin
    buf_we    = 1'b0;
    buf_waddr = acc_ptr_reg;
    buf_wdata = i_pwdata[7:0];
    if (clr_active_reg) begin
      buf_we    = 1'b1;
      buf_waddr = clr_addr_reg[7:0];
      buf_wdata = 8'h00;
    end else if (rx_byte_evt) begin
      buf_we    = 1'b1;
      buf_waddr = wpos_reg;
      buf_wdata = lk.rx_byte;
    end else if (wr && data_acc && mode_reg != MODE_SLEEP) begin
      buf_we    = 1'b1;
    end
  end

  rps_buffer u_buf (
    .i_clock   (i_clock),
    .i_we      (buf_we),
    .i_waddr   (buf_waddr),
    .i_wdata   (buf_wdata),
    .i_raddr_a (acc_ptr_reg),
    .o_rdata_a (buf_rd),
    .i_raddr_b (tx_ptr_reg),
    .o_rdata_b (tx_rd)
  );

  always_comb begin
    mapped    = 1'b1;
    rdata_mux = 32'h0000_0000;
    unique case (i_paddr)
      OFF_MODE:       rdata_mux[2:0] = mode_reg;
      OFF_FLAGS:      rdata_mux[4:0] = flags_reg;
      OFF_ACC_PTR:    rdata_mux[7:0] = acc_ptr_reg;
      OFF_DATA:       rdata_mux[7:0] = buf_rd;
      OFF_TX_START:   rdata_mux[7:0] = tx_start_reg;
      OFF_RX_START:   rdata_mux[7:0] = rx_start_reg;
      OFF_LAST_START: rdata_mux[7:0] = last_start_reg;
      OFF_RX_COUNT:   rdata_mux[7:0] = rx_count_reg;
      OFF_RX_WPOS:    rdata_mux[7:0] = wpos_reg;
      OFF_TX_SIZE:    rdata_mux[7:0] = tx_size_reg;
      OFF_WIN_LEN:    rdata_mux[9:0] = win_len_reg;
      OFF_PRE_LEN:    rdata_mux[15:0] = pre_len_reg;
      default:        mapped = 1'b0;
    endcase
  end

  // APB answer one cycle after the access phase starts, later while a data access is stalled
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= xfer;
      // (RULE_22) data port refused in sleep
      pslverr_reg <= xfer & (~mapped | (data_acc & (mode_reg == MODE_SLEEP)));
      prdata_reg  <= (xfer && !i_pwrite && mapped) ? rdata_mux : 32'h0000_0000;
    end
  end

  // Configuration registers
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tx_start_reg <= RST_TX_START;
      rx_start_reg <= RST_RX_START;
      tx_size_reg  <= RST_TX_SIZE;
      win_len_reg  <= RST_WIN_LEN;
      pre_len_reg  <= RST_PRE_LEN;
    end else if (wr) begin
      if (i_paddr == OFF_TX_START) tx_start_reg <= i_pwdata[7:0];
      if (i_paddr == OFF_RX_START) rx_start_reg <= i_pwdata[7:0];
      if (i_paddr == OFF_TX_SIZE)  tx_size_reg  <= i_pwdata[7:0];
      if (i_paddr == OFF_WIN_LEN)  win_len_reg  <= i_pwdata[9:0];
      if (i_paddr == OFF_PRE_LEN)  pre_len_reg  <= i_pwdata[15:0];
    end
  end

  // Mode: host request wins over the automatic return
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      mode_reg      <= MODE_SLEEP;
      mode_prev_reg <= MODE_SLEEP;
      enter_reg     <= 1'b0;
      lclk_prev_reg <= 1'b0;
    end else begin
      mode_prev_reg <= mode_reg;
      lclk_prev_reg <= lk.lclk;
      enter_reg     <= mode_wr & ((i_pwdata[2:0] == MODE_RX_SINGLE)
                       | ((i_pwdata[2:0] == MODE_RX_CONT) & ~cont));
      if (mode_wr) begin
        mode_reg <= i_pwdata[2:0];
      // (RULE_03) return to standby after transmit
      end else if (tx_end_evt) begin
        mode_reg <= MODE_STANDBY;
      // (RULE_07) (RULE_14) only single receive returns
      end else if (single && (rx_end_evt || expire_evt)) begin
        mode_reg <= MODE_STANDBY;
      end
    end
  end

  // Event flags: write one to clear, a new event wins
  always_comb begin
    flag_set = 5'h00;
    flag_set[FLG_TX_DONE]  = tx_end_evt;
    flag_set[FLG_RX_DONE]  = rx_end_evt;
    flag_set[FLG_EXPIRED]  = expire_evt;
    flag_set[FLG_CHK_FAIL] = rx_end_evt & lk.crc_bad;
    flag_set[FLG_HDR_OK]   = hdr_evt;
    flag_clr = (wr && i_paddr == OFF_FLAGS) ? i_pwdata[4:0] : 5'h00;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      flags_reg <= 5'h00;
    end else begin
      // (RULE_06) check fail raised with receive end
      flags_reg <= (flags_reg & ~flag_clr) | flag_set;
    end
  end

  // Receive sequencing
  always_ff @(posedge i_clock) begin
    if (i_srst || !rx_on) begin
      rx_state_reg <= RX_IDLE;
    end else if (enter_reg) begin
      rx_state_reg <= RX_SEARCH;
    end else begin
      unique case (rx_state_reg)
        RX_IDLE:   rx_state_reg <= RX_SEARCH;
        RX_SEARCH: if (tick && lk.pre_det) rx_state_reg <= RX_PREAMBLE;
        RX_PREAMBLE: begin
          // (RULE_08) header accepted in either receive mode
          if (hdr_evt) begin
            rx_state_reg <= RX_PAYLOAD;
          // (RULE_11) overlong preamble dropped without flag
          end else if (cont && tick && pre_cnt_reg > pre_len_reg) begin
            rx_state_reg <= RX_SEARCH;
          end
        end
        RX_PAYLOAD: begin
          // (RULE_10) continuous mode searches again
          if (rx_end_evt) rx_state_reg <= cont ? RX_SEARCH : RX_IDLE;
        end
      endcase
    end
  end

  // Preamble length and receive window counters
  always_ff @(posedge i_clock) begin
    if (i_srst || !rx_on || enter_reg) begin
      pre_cnt_reg <= 16'h0000;
      win_cnt_reg <= 10'h000;
      fired_reg   <= 1'b0;
    end else begin
      if (rx_state_reg != RX_PREAMBLE) pre_cnt_reg <= 16'h0000;
      else if (tick)                   pre_cnt_reg <= pre_cnt_reg + 16'h0001;
      if (tick && !fired_reg)          win_cnt_reg <= win_cnt_reg + 10'h001;
      // (RULE_12) timeout fires once, mode unchanged
      if (expire_evt)                  fired_reg <= 1'b1;
    end
  end

  // Receive write position and packet status
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      wpos_reg       <= RST_RX_START;
      cur_start_reg  <= RST_RX_START;
      last_start_reg <= RST_RX_START;
      rx_count_reg   <= 8'h00;
    end else begin
      // (RULE_13) write position kept across continuous packets
      if (enter_reg)        wpos_reg <= rx_start_reg;
      // (RULE_20) (RULE_25) next receive address, wraps
      else if (rx_byte_evt) wpos_reg <= wpos_reg + 8'h01;
      if (hdr_evt)          cur_start_reg <= wpos_reg;
      // (RULE_15) status of latest packet only
      if (rx_end_evt)       last_start_reg <= cur_start_reg;
      // (RULE_17) bytes of current packet so far
      if (hdr_evt)          rx_count_reg <= 8'h00;
      else if (rx_byte_evt) rx_count_reg <= rx_count_reg + 8'h01;
    end
  end

  // Host access pointer and transmit read pointer
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      acc_ptr_reg <= 8'h00;
      tx_ptr_reg  <= RST_TX_START;
    end else begin
      if (wr && i_paddr == OFF_ACC_PTR) begin
        acc_ptr_reg <= i_pwdata[7:0];
      // (RULE_23) data port advances pointer, wraps
      end else if (xfer && data_acc && mode_reg != MODE_SLEEP) begin
        acc_ptr_reg <= acc_ptr_reg + 8'h01;
      end
      if (mode_wr && i_pwdata[2:0] == MODE_TX) tx_ptr_reg <= tx_start_reg;
      else if (tick && lk.tx_take && mode_reg == MODE_TX) tx_ptr_reg <= tx_ptr_reg + 8'h01;
    end
  end

  // Clearing sweep on reset and on every entry to sleep
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      clr_active_reg <= 1'b1;
      clr_addr_reg   <= 9'h000;
    // (RULE_24) sleep entry zeroes the buffer
    end else if (mode_reg == MODE_SLEEP && mode_prev_reg != MODE_SLEEP) begin
      clr_active_reg <= 1'b1;
      clr_addr_reg   <= 9'h000;
    end else if (clr_active_reg) begin
      clr_active_reg <= (clr_addr_reg != RPS_CLR_LAST);
      clr_addr_reg   <= clr_addr_reg + 9'h001;
    end
  end

  // Radio controls
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_rf_en     <= 1'b0;
      o_pll_en    <= 1'b0;
      o_pa_en     <= 1'b0;
      o_gain_hold <= 1'b0;
      o_tx_byte   <= 8'h00;
      o_tx_size   <= RST_TX_SIZE;
    end else begin
      // (RULE_03) PA only for the packet; RF also in receive, PLL also in receive and both synth modes
      o_rf_en     <= rx_on | (mode_reg == MODE_TX);
      o_pa_en     <= (mode_reg == MODE_TX);
      o_pll_en    <= rx_on | (mode_reg == MODE_TX) | (mode_reg == MODE_TX_SYNTH)
                     | (mode_reg == MODE_RX_SYNTH);
      o_gain_hold <= (rx_state_reg == RX_PREAMBLE) | (rx_state_reg == RX_PAYLOAD);
      o_tx_byte   <= tx_rd;
      o_tx_size   <= tx_size_reg;
    end
  end

  assign o_prdata  = prdata_reg;
  assign o_pready  = pready_reg;
  assign o_pslverr = pslverr_reg;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  tx_return_a: assert property (tx_end_evt && !mode_wr |=> // RULE_03
    mode_reg == MODE_STANDBY && flags_reg[FLG_TX_DONE] ##1 !o_pa_en)
    else $error("transmit did not finish in standby");
  win_expire_a: assert property (expire_evt && single && !mode_wr |=> // RULE_05
    mode_reg == MODE_STANDBY && flags_reg[FLG_EXPIRED])
    else $error("window expiry not handled");
  check_fail_a: assert property (rx_end_evt && lk.crc_bad |=> // RULE_06
    flags_reg[FLG_CHK_FAIL] && flags_reg[FLG_RX_DONE])
    else $error("check fail flag missing");
  single_off_a: assert property (rx_end_evt && single && !mode_wr |=> // RULE_07
    ##1 !o_rf_en && rx_state_reg == RX_IDLE)
    else $error("radio left on after single receive");
  header_flag_a: assert property (hdr_evt |=> flags_reg[FLG_HDR_OK] // RULE_08
    && o_gain_hold) else $error("header flag or gain hold missing");
  cont_stay_a: assert property (rx_end_evt && cont && !mode_wr |=> // RULE_14
    cont && rx_state_reg == RX_SEARCH) else $error("continuous receive left");
  wpos_step_a: assert property (rx_byte_evt && !enter_reg |=> // RULE_20
    wpos_reg == $past(wpos_reg) + 8'h01) else $error("write position not advanced");
  ptr_step_a: assert property (xfer && data_acc && mode_reg != MODE_SLEEP // RULE_23
    && !(wr && i_paddr == OFF_ACC_PTR) |=> acc_ptr_reg == $past(acc_ptr_reg) + 8'h01)
    else $error("access pointer not advanced");
  sleep_refuse_a: assert property (xfer && data_acc && mode_reg == MODE_SLEEP // RULE_22
    |=> o_pready && o_pslverr) else $error("sleep buffer access not refused");

  tx_done_c: cover property (tx_end_evt);
  single_expire_c: cover property (expire_evt && single);
  cont_packet_c: cover property (rx_end_evt && cont);
endmodule

// File: src/rps_sync.sv
// Two-stage synchroniser for a vector of modem inputs
`timescale 1ns/10ps
module rps_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clock,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic stage1_reg;
      logic stage2_reg;
      always_ff @(posedge i_clock) begin
        if (i_srst) begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
        end else begin
          stage1_reg <= i_async[g];
          stage2_reg <= stage1_reg;
        end
      end
      assign o_sync[g] = stage2_reg;
    end
  endgenerate
endmodule

// File: test/rps_modem_model.sv
// Behavioural modem side that drives the link struct of the sequencer
`timescale 1ns/10ps
module rps_modem_model import rps_pkg::*; (
  output rps_link_t o_link
);
  rps_link_t lnk;

  assign o_link = lnk;

  initial begin
    lnk = '0;
  end

  // One link period; the clock stands still outside these calls
  task automatic tick();
    #80 lnk.lclk <= 1'b1;
    #80 lnk.lclk <= 1'b0;
  endtask

  task automatic preamble(input logic on);
    lnk.pre_det <= on;
  endtask

  // Event held for one link period, payload line inverted once released
  task automatic ev(input int kind, input logic [7:0] b);
    lnk.rx_byte    <= b;
    lnk.hdr_ok     <= (kind == 0);
    lnk.byte_valid <= (kind == 1);
    lnk.rx_end     <= (kind == 2) || (kind == 3);
    lnk.crc_bad    <= (kind == 3);
    lnk.tx_end     <= (kind == 4);
    lnk.tx_take    <= (kind == 5);
    tick();
    lnk.hdr_ok     <= 1'b0;
    lnk.byte_valid <= 1'b0;
    lnk.rx_end     <= 1'b0;
    lnk.crc_bad    <= 1'b0;
    lnk.tx_end     <= 1'b0;
    lnk.tx_take    <= 1'b0;
    lnk.rx_byte    <= ~b;
  endtask
endmodule

// File: test/testbench.sv
// Self-checking bench of the packet sequencer over APB and the modem link
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_count++; \
  $display("mismatch at %0t: got %0h exp %0h", $time, got, exp); end end
module testbench import rps_pkg::*;;
  localparam int EV_HDR = 0, EV_BYTE = 1, EV_OK = 2, EV_BAD = 3, EV_TXEND = 4, EV_TAKE = 5;
  logic        clock;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  rps_link_t   link;
  logic        rf_en;
  logic        pll_en;
  logic        pa_en;
  logic        gain_hold;
  logic [7:0]  tx_byte;
  logic [7:0]  tx_size;
  int          err_count;
  int          check_count;
  int          cyc;

  rps_sequencer rps_sequencer_i (
    .i_clock(clock), .i_srst(srst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_link(link), .o_rf_en(rf_en),
    .o_pll_en(pll_en), .o_pa_en(pa_en), .o_gain_hold(gain_hold),
    .o_tx_byte(tx_byte), .o_tx_size(tx_size)
  );
  rps_modem_model rps_modem_model_i (.o_link(link));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r, x)
  endtask

  task automatic refused(input logic w, input logic [7:0] a);
    logic [31:0] r;
    logic        e;
    apb(w, a, 32'h0000005A, r, e);
    `CHK(e, 1'b1)
  endtask

  task automatic tk(input int n);
    repeat (n) rps_modem_model_i.tick();
  endtask

  task automatic ev(input int k, input logic [7:0] b);
    rps_modem_model_i.ev(k, b);
  endtask

  initial begin
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; err_count = 0; check_count = 0; cyc = 0;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    rc(OFF_MODE, 32'h0);
    rc(OFF_TX_START, 32'h80);
    rc(OFF_RX_START, 32'h0);
    rc(OFF_TX_SIZE, 32'h1);
    rc(OFF_WIN_LEN, 32'h5);
    rc(OFF_PRE_LEN, 32'h8);
    refused(1'b0, 8'h30);
    refused(1'b0, OFF_DATA);
    refused(1'b1, OFF_DATA);
    $display("test reset done");
    wr(OFF_MODE, MODE_STANDBY);
    wr(OFF_TX_SIZE, 32'h2);
    wr(OFF_ACC_PTR, 32'h80);
    wr(OFF_DATA, 32'hA5);
    wr(OFF_DATA, 32'h3C);
    rc(OFF_ACC_PTR, 32'h82);
    wr(OFF_MODE, MODE_TX);
    rc(OFF_MODE, MODE_TX);
    `CHK({rf_en, pll_en, pa_en, tx_byte, tx_size}, {3'h7, 8'hA5, 8'h02})
    ev(EV_TAKE, 8'h00);
    ev(EV_TXEND, 8'h00);
    rc(OFF_FLAGS, 32'h01);
    rc(OFF_MODE, MODE_STANDBY);
    `CHK({rf_en, pll_en, pa_en, tx_byte}, {3'h0, 8'h3C})
    wr(OFF_FLAGS, 32'h1F);
    $display("test transmit done");
    wr(OFF_MODE, MODE_TX_SYNTH);
    wr(OFF_MODE, 32'h7);
    rc(OFF_MODE, MODE_TX_SYNTH);
    `CHK({rf_en, pll_en, pa_en}, 3'h2)
    wr(OFF_MODE, MODE_RX_SYNTH);
    wr(OFF_WIN_LEN, 32'h4);
    `CHK({rf_en, pll_en, pa_en}, 3'h2)
    wr(OFF_MODE, MODE_RX_SINGLE);
    tk(3);
    rc(OFF_FLAGS, 32'h00);
    tk(2);
    rc(OFF_FLAGS, 32'h04);
    rc(OFF_MODE, MODE_STANDBY);
    `CHK({rf_en, pll_en}, 2'h0)
    wr(OFF_FLAGS, 32'h1F);
    $display("test window done");
    wr(OFF_RX_START, 32'h10);
    wr(OFF_MODE, MODE_RX_SINGLE);
    rps_modem_model_i.preamble(1'b1);
    tk(1);
    rc(OFF_MODE, MODE_RX_SINGLE);
    `CHK(gain_hold, 1'b1)
    ev(EV_HDR, 8'h00);
    rps_modem_model_i.preamble(1'b0);
    rc(OFF_FLAGS, 32'h10);
    ev(EV_BYTE, 8'h11);
    ev(EV_BYTE, 8'h22);
    ev(EV_BYTE, 8'h33);
    rc(OFF_RX_COUNT, 32'h3);
    rc(OFF_RX_WPOS, 32'h13);
    ev(EV_BAD, 8'h00);
    rc(OFF_FLAGS, 32'h1A);
    rc(OFF_MODE, MODE_STANDBY);
    `CHK({rf_en, pll_en}, 2'h0)
    rc(OFF_LAST_START, 32'h10);
    wr(OFF_ACC_PTR, 32'h10);
    rc(OFF_DATA, 32'h11);
    rc(OFF_DATA, 32'h22);
    rc(OFF_DATA, 32'h33);
    wr(OFF_FLAGS, 32'h1F);
    $display("test single receive done");
    wr(OFF_RX_START, 32'hFE);
    wr(OFF_MODE, MODE_RX_CONT);
    tk(5);
    rc(OFF_FLAGS, 32'h04);
    rc(OFF_MODE, MODE_RX_CONT);
    wr(OFF_FLAGS, 32'h1F);
    rps_modem_model_i.preamble(1'b1);
    tk(10);
    rps_modem_model_i.preamble(1'b0);
    tk(1);
    rc(OFF_FLAGS, 32'h00);
    `CHK(gain_hold, 1'b0)
    rps_modem_model_i.preamble(1'b1);
    tk(1);
    ev(EV_HDR, 8'h00);
    rps_modem_model_i.preamble(1'b0);
    ev(EV_BYTE, 8'h41);
    ev(EV_BYTE, 8'h42);
    ev(EV_BYTE, 8'h43);
    ev(EV_OK, 8'h00);
    rc(OFF_FLAGS, 32'h12);
    rc(OFF_MODE, MODE_RX_CONT);
    rc(OFF_RX_WPOS, 32'h01);
    rc(OFF_LAST_START, 32'hFE);
    wr(OFF_FLAGS, 32'h1F);
    rps_modem_model_i.preamble(1'b1);
    tk(1);
    ev(EV_HDR, 8'h00);
    rps_modem_model_i.preamble(1'b0);
    rc(OFF_RX_WPOS, 32'h01);
    ev(EV_BYTE, 8'h44);
    ev(EV_OK, 8'h00);
    rc(OFF_RX_WPOS, 32'h02);
    rc(OFF_LAST_START, 32'h01);
    rc(OFF_RX_COUNT, 32'h1);
    wr(OFF_MODE, MODE_STANDBY);
    wr(OFF_ACC_PTR, 32'h01);
    rc(OFF_DATA, 32'h44);
    wr(OFF_ACC_PTR, 32'hFE);
    rc(OFF_DATA, 32'h41);
    rc(OFF_DATA, 32'h42);
    rc(OFF_DATA, 32'h43);
    $display("test continuous receive done");
    wr(OFF_MODE, MODE_SLEEP);
    wr(OFF_MODE, MODE_STANDBY);
    wr(OFF_ACC_PTR, 32'h01);
    rc(OFF_DATA, 32'h00);
    $display("test sleep done");
    complete_run();
  end
endmodule
